// ==== src/rwc_pkg.sv ====
// Purpose: Shared constants and types of the register window control block
// Assumes: Eight windows, single core clock, synchronous active-high reset
// Notes:   Software register map sits on a classic Wishbone slave
//
// Behaviour
// RQ1: Save increments the window pointer
// RQ2: Save with no savable window raises spill
// RQ3: Save with no clean window raises clean-window
// RQ4: Good save adds, savable down, restorable up
// RQ5: Add reads old window, writes new window
// RQ6: Restore decrements the window pointer
// RQ7: Restore with no restorable window raises fill
// RQ8: Good restore adds, restorable down, savable up
// RQ9: Saved: savable up, other or restorable down
// RQ10: Restored: restorable up, other or savable down, clean
// RQ11: Flush traps spill when windows minus two minus savable nonzero
// RQ12: Flush retried keeps spilling until all flushed
// RQ13: Pointer wraps; nonzero other count selects other
package rwc_pkg;

   // ==========================================================
   // Window geometry and reset values
   localparam int          NWIN         = 8;
   localparam int          WW           = 3;
   localparam logic [2:0]  PTR_RST      = 3'h0;
   localparam logic [2:0]  SAVABLE_RST  = 3'h6;
   localparam logic [2:0]  RESTOR_RST   = 3'h0;
   localparam logic [2:0]  CLEAN_RST    = 3'h7;
   localparam logic [2:0]  OTHER_RST    = 3'h0;
   localparam logic [2:0]  FLUSH_BASE   = 3'h6;
   localparam logic [2:0]  CLEAN_MAX    = 3'h7;

   // ==========================================================
   // Register map (byte addresses) and field positions
   localparam logic [7:0]  OFS_WSTATE   = 8'h00;
   localparam logic [7:0]  OFS_ISTAT    = 8'h04;
   localparam logic [7:0]  OFS_IMASK    = 8'h08;
   localparam int          POS_PTR      = 0;
   localparam int          POS_SAVABLE  = 4;
   localparam int          POS_RESTOR   = 8;
   localparam int          POS_CLEAN    = 12;
   localparam int          POS_OTHER    = 16;
   localparam int          NIRQ         = 3;
   localparam int          IRQ_SPILL    = 0;
   localparam int          IRQ_FILL     = 1;
   localparam int          IRQ_CLEAN    = 2;
   localparam logic [2:0]  IMASK_RST    = 3'h0;

   // ==========================================================
   // Operation and trap encodings
   typedef enum logic [2:0] {
      OP_NONE     = 3'h0,
      OP_SAVE     = 3'h1,
      OP_RESTORE  = 3'h3,
      OP_SAVED    = 3'h2,
      OP_RESTORED = 3'h6,
      OP_FLUSH    = 3'h7
   } rwc_op_e;

   typedef enum logic [1:0] {
      TR_NONE  = 2'h0,
      TR_SPILL = 2'h1,
      TR_FILL  = 2'h3,
      TR_CLEAN = 2'h2
   } rwc_trap_e;

endpackage

// ==== src/rwc_win_cnt.sv ====
// Purpose: One window-accounting counter with load, increment, decrement
// Assumes: Increment and decrement never both asserted
// Notes:   Arithmetic is modulo two to the width, which wraps the pointer
`timescale 1ns/100ps
module rwc_win_cnt
   import rwc_pkg::*;
#(
   parameter int          W   = 3,
   parameter logic [2:0]  RST = 3'h0
)(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Control
   input  wire logic          ld_i,
   input  wire logic [W-1:0]  ld_val_i,
   input  wire logic          inc_i,
   input  wire logic          dec_i,
   // Value
   output logic      [W-1:0]  cnt_o
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } rwc_cnt_s;

   rwc_cnt_s st_ff;
   rwc_cnt_s nxt_st;

   // ==========================================================
   // Next value; a software load overrides any update
   always_comb
   begin
      nxt_st = st_ff;
      if (ld_i)
      begin
         nxt_st.cnt = ld_val_i;
      end
      else if (inc_i)
      begin
         nxt_st.cnt = W'(st_ff.cnt + 1'b1); // RQ13
      end
      else if (dec_i)
      begin
         nxt_st.cnt = W'(st_ff.cnt - 1'b1); // RQ13
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff.cnt <= W'(RST);
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign cnt_o = st_ff.cnt;

endmodule

// ==== src/rwc_ctrl.sv ====
// Purpose: Window pointer, accounting counters and window exceptions
// Assumes: At most one window operation offered per cycle, same clock
// Notes:   Results appear one cycle after the operation is offered
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
module rwc_ctrl
   import rwc_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // Wishbone slave
   input  wire logic          cyc_i,
   input  wire logic          stb_i,
   input  wire logic          we_i,
   input  wire logic [7:0]    adr_i,
   input  wire logic [3:0]    sel_i,
   input  wire logic [31:0]   dat_i,
   output logic      [31:0]   dat_o,
   output logic               ack_o,
   // Window operation from the pipeline
   input  wire logic          op_valid_i,
   input  wire logic [2:0]    op_code_i,
   // Result towards pipeline and trap logic
   output logic               done_o,
   output logic               add_en_o,
   output logic      [2:0]    src_win_o,
   output logic      [2:0]    dst_win_o,
   output logic               trap_o,
   output logic      [1:0]    trap_type_o,
   output logic               trap_other_o,
   // Interrupt
   output logic               irq_o
);

   typedef struct packed {
      logic               ack;
      logic [31:0]        dat;
      logic [NIRQ-1:0]    stat;
      logic [NIRQ-1:0]    mask;
      logic               irq;
      logic               done;
      logic               add_en;
      logic [2:0]         src;
      logic [2:0]         dst;
      logic               trap;
      logic [1:0]         ttype;
      logic               tother;
   } rwc_ctrl_s;

   rwc_ctrl_s    st_ff;
   rwc_ctrl_s    nxt_st;

   logic [2:0]   wptr;
   logic [2:0]   savable;
   logic [2:0]   restor;
   logic [2:0]   clean;
   logic [2:0]   other;
   logic         is_save;
   logic         is_rest;
   logic         is_saved;
   logic         is_restd;
   logic         is_flush;
   logic         other_nz;
   logic         spill_sv;
   logic         clean_sv;
   logic         save_ok;
   logic         fill_rs;
   logic         rest_ok;
   logic         flush_tr;
   logic [2:0]   flush_cnt;
   logic         acc;
   logic         commit;
   logic         st_wr;
   logic [31:0]  bmask;
   logic [31:0]  ws_rd;
   logic [31:0]  ws_new;
   logic [31:0]  rd_mux;
   logic [NIRQ-1:0] ev;

   // ==========================================================
   // Operation decode and exception checks
   assign is_save  = op_valid_i && (op_code_i == OP_SAVE);
   assign is_rest  = op_valid_i && (op_code_i == OP_RESTORE);
   assign is_saved = op_valid_i && (op_code_i == OP_SAVED);
   assign is_restd = op_valid_i && (op_code_i == OP_RESTORED);
   assign is_flush = op_valid_i && (op_code_i == OP_FLUSH);
   assign other_nz = (other != 3'h0);
   assign spill_sv = is_save && (savable == 3'h0); // RQ2
   // Clean windows are counted modulo the window count
   assign clean_sv = is_save && (savable != 3'h0)
                     && (3'(clean - restor) == 3'h0); // RQ3
   assign save_ok  = is_save && !spill_sv && !clean_sv;
   assign fill_rs  = is_rest && (restor == 3'h0); // RQ7
   assign rest_ok  = is_rest && !fill_rs;
   assign flush_cnt = 3'(FLUSH_BASE - savable);
   // Each retried flush re-evaluates the count, so traps repeat
   assign flush_tr = is_flush && (flush_cnt != 3'h0); // RQ11 RQ12

   // ==========================================================
   // Bus decode; a write lands on the edge where ack is seen
   assign acc    = cyc_i && stb_i;
   assign commit = acc && st_ff.ack;
   assign st_wr  = commit && we_i && (adr_i == OFS_WSTATE);
   assign bmask  = {{8{sel_i[3]}}, {8{sel_i[2]}},
                    {8{sel_i[1]}}, {8{sel_i[0]}}};
   always_comb
   begin
      ws_rd = 32'h0;
      ws_rd[POS_PTR     +: 3] = wptr;
      ws_rd[POS_SAVABLE +: 3] = savable;
      ws_rd[POS_RESTOR  +: 3] = restor;
      ws_rd[POS_CLEAN   +: 3] = clean;
      ws_rd[POS_OTHER   +: 3] = other;
   end
   assign ws_new = (ws_rd & ~bmask) | (dat_i & bmask);

   always_comb
   begin
      rd_mux = 32'h0;
      case (adr_i)
         OFS_WSTATE: rd_mux = ws_rd;
         OFS_ISTAT:  rd_mux = {{(32-NIRQ){1'b0}}, st_ff.stat};
         OFS_IMASK:  rd_mux = {{(32-NIRQ){1'b0}}, st_ff.mask};
         default:    rd_mux = 32'h0;
      endcase
   end

   // ==========================================================
   // Window pointer and accounting counters
   rwc_win_cnt #(.W(WW), .RST(PTR_RST)) u_wptr (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ld_i     (st_wr),
      .ld_val_i (ws_new[POS_PTR +: 3]),
      .inc_i    (save_ok), // RQ1
      .dec_i    (rest_ok), // RQ6
      .cnt_o    (wptr)
   );

   rwc_win_cnt #(.W(WW), .RST(SAVABLE_RST)) u_savable (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ld_i     (st_wr),
      .ld_val_i (ws_new[POS_SAVABLE +: 3]),
      .inc_i    (rest_ok || is_saved), // RQ8 RQ9
      .dec_i    (save_ok || (is_restd && !other_nz)), // RQ4 RQ10
      .cnt_o    (savable)
   );

   rwc_win_cnt #(.W(WW), .RST(RESTOR_RST)) u_restor (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ld_i     (st_wr),
      .ld_val_i (ws_new[POS_RESTOR +: 3]),
      .inc_i    (save_ok || is_restd), // RQ4 RQ10
      .dec_i    (rest_ok || (is_saved && !other_nz)), // RQ8 RQ9
      .cnt_o    (restor)
   );

   // Clean count saturates at the last window
   rwc_win_cnt #(.W(WW), .RST(CLEAN_RST)) u_clean (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ld_i     (st_wr),
      .ld_val_i (ws_new[POS_CLEAN +: 3]),
      .inc_i    (is_restd && (clean != CLEAN_MAX)), // RQ10
      .dec_i    (1'b0),
      .cnt_o    (clean)
   );

   rwc_win_cnt #(.W(WW), .RST(OTHER_RST)) u_other (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ld_i     (st_wr),
      .ld_val_i (ws_new[POS_OTHER +: 3]),
      .inc_i    (1'b0),
      .dec_i    ((is_saved || is_restd) && other_nz), // RQ9 RQ10
      .cnt_o    (other)
   );

   // ==========================================================
   // Results, traps, interrupt status and bus answer
   assign ev[IRQ_SPILL] = spill_sv || flush_tr;
   assign ev[IRQ_FILL]  = fill_rs;
   assign ev[IRQ_CLEAN] = clean_sv;

   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.ack    = acc && !st_ff.ack;
      if (acc && !st_ff.ack)
      begin
         nxt_st.dat = rd_mux;
      end
      if (commit && we_i && (adr_i == OFS_IMASK))
      begin
         nxt_st.mask = (st_ff.mask & ~bmask[NIRQ-1:0])
                       | (dat_i[NIRQ-1:0] & bmask[NIRQ-1:0]);
      end
      // Read clears, but an event in the same cycle still sets
      if (commit && !we_i && (adr_i == OFS_ISTAT))
      begin
         nxt_st.stat = ev;
      end
      else
      begin
         nxt_st.stat = st_ff.stat | ev;
      end
      // A set mask bit silences its event
      nxt_st.irq    = |(nxt_st.stat & ~nxt_st.mask);
      nxt_st.done   = save_ok || rest_ok || is_saved || is_restd
                      || (is_flush && !flush_tr);
      nxt_st.add_en = save_ok || rest_ok; // RQ4 RQ8
      nxt_st.src    = wptr; // RQ5
      nxt_st.dst    = save_ok ? 3'(wptr + 3'h1)
                    : rest_ok ? 3'(wptr - 3'h1) : wptr; // RQ5
      nxt_st.trap   = spill_sv || clean_sv || fill_rs || flush_tr;
      nxt_st.ttype  = (spill_sv || flush_tr) ? TR_SPILL
                    : fill_rs ? TR_FILL
                    : clean_sv ? TR_CLEAN : TR_NONE;
      nxt_st.tother = (spill_sv || flush_tr || fill_rs)
                      && other_nz; // RQ13
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_ff      <= '0;
         st_ff.mask <= IMASK_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign ack_o        = st_ff.ack;
   assign dat_o        = st_ff.dat;
   assign done_o       = st_ff.done;
   assign add_en_o     = st_ff.add_en;
   assign src_win_o    = st_ff.src;
   assign dst_win_o    = st_ff.dst;
   assign trap_o       = st_ff.trap;
   assign trap_type_o  = st_ff.ttype;
   assign trap_other_o = st_ff.tother;
   assign irq_o        = st_ff.irq;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_save_ptr: assert property (save_ok && !st_wr |=> // RQ1
      wptr == 3'($past(wptr) + 3'h1))
      else $error("save did not advance pointer");
   chk_save_spill: assert property (is_save && savable == 3'h0 |=> // RQ2
      trap_o && trap_type_o == TR_SPILL && !done_o)
      else $error("save without savable window did not spill");
   chk_save_clean: assert property (clean_sv |=> // RQ3
      trap_o && trap_type_o == TR_CLEAN && $stable(wptr))
      else $error("clean-window trap missing");
   chk_save_counts: assert property (save_ok && !st_wr |=> // RQ4
      savable == 3'($past(savable) - 3'h1)
      && restor == 3'($past(restor) + 3'h1) && add_en_o)
      else $error("save counts wrong");
   chk_add_windows: assert property (add_en_o |-> // RQ5
      (dst_win_o == wptr) && (src_win_o != dst_win_o))
      else $error("add windows wrong");
   chk_rest_ptr: assert property (rest_ok && !st_wr |=> // RQ6
      wptr == 3'($past(wptr) - 3'h1))
      else $error("restore did not step pointer back");
   chk_rest_fill: assert property (is_rest && restor == 3'h0 |=> // RQ7
      trap_o && trap_type_o == TR_FILL && !add_en_o)
      else $error("restore without restorable window did not fill");
   chk_rest_counts: assert property (rest_ok && !st_wr |=> // RQ8
      restor == 3'($past(restor) - 3'h1)
      && savable == 3'($past(savable) + 3'h1))
      else $error("restore counts wrong");
   chk_saved_counts: assert property (is_saved && !st_wr |=> // RQ9
      savable == 3'($past(savable) + 3'h1)
      && (($past(other) != 3'h0) ? other == 3'($past(other) - 3'h1)
          : restor == 3'($past(restor) - 3'h1)))
      else $error("saved counts wrong");
   chk_restd_counts: assert property (is_restd && !st_wr |=> // RQ10
      restor == 3'($past(restor) + 3'h1)
      && (($past(other) != 3'h0) ? other == 3'($past(other) - 3'h1)
          : savable == 3'($past(savable) - 3'h1)))
      else $error("restored counts wrong");
   chk_flush_trap: assert property (is_flush |=> // RQ11
      trap_o == ($past(savable) != FLUSH_BASE) && $stable(wptr))
      else $error("flush trap decision wrong");
   chk_trap_other: assert property (trap_o && trap_type_o != TR_CLEAN
      |-> trap_other_o == ($past(other) != 3'h0)) // RQ13
      else $error("trap variety wrong");
   chk_bus_ack: assert property (acc && !ack_o |=> ack_o ##1 !ack_o)
      else $error("bus answer not one cycle");

   cov_save_ok:   cover property (save_ok ##1 add_en_o);
   cov_spill:     cover property (spill_sv ##1 irq_o);
   cov_flush_rep: cover property (flush_tr ##[1:20] flush_tr);
   cov_restd:     cover property (is_restd && other_nz);

endmodule

// ==== verif/rwc_pipe_model.sv ====
// Purpose: Pipeline and spill handler stand-in that offers window ops
// Assumes: Bench requests one op at a time while the handler is idle
// Notes:   A flush spill is answered by saved, then the flush is retried
`timescale 1ns/100ps
module rwc_pipe_model
   import rwc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Request from the bench
   input  wire logic       req_i,
   input  wire logic [2:0] req_code_i,
   // Towards and from the block
   output logic            op_valid_o,
   output logic      [2:0] op_code_o,
   input  wire logic       done_i,
   input  wire logic       trap_i,
   input  wire logic [1:0] trap_type_i,
   // Status
   output logic            flush_ok_o,
   output logic      [3:0] spills_o
);
   logic [1:0] step;
   logic       took_flush;

   // Done belongs to a flush only when the op taken last edge was one
   assign flush_ok_o = done_i & took_flush;

   // ==========================================================
   // Op driver and retrying spill handler
   always_ff @(posedge clk_i)
   begin
      op_valid_o <= 1'b0;
      took_flush <= op_valid_o && op_code_o == OP_FLUSH;
      if (rst_i)
      begin
         step <= 2'h0;
         op_code_o <= OP_NONE;
         spills_o <= 4'h0;
      end
      else if (step == 2'h1)
      begin
         op_valid_o <= 1'b1;
         op_code_o <= OP_SAVED;
         step <= 2'h2;
      end
      else if (step == 2'h2)
      begin
         op_valid_o <= 1'b1;
         op_code_o <= OP_FLUSH;
         step <= 2'h0;
      end
      else if (req_i)
      begin
         op_valid_o <= 1'b1;
         op_code_o <= req_code_i;
      end
      if (!rst_i && trap_i && trap_type_i == TR_SPILL && took_flush)
      begin
         step <= 2'h1;
         spills_o <= spills_o + 4'h1;
      end
   end
endmodule

// ==== verif/tb_rwc_ctrl.sv ====
// Purpose: Self-checking bench of the window control block
// Assumes: Wishbone master and op requests driven at rising edges
// Notes:   Every scenario reads the window state back over the bus
`timescale 1ns/100ps
module tb_rwc_ctrl
   import rwc_pkg::*;
();
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] wdat  = 32'h0;
   logic        req   = 1'b0;
   logic [2:0]  code  = 3'h0;
   logic [31:0] rd, rdat;
   logic        ack, opv, done, adden, trap, toth, irq, fok;
   logic [2:0]  opc, src, dst;
   logic [1:0]  ttype;
   logic [3:0]  spills;
   int          errors = 0;
   int          check_count = 0;

   always #12.5 clk_i = ~clk_i;

   rwc_ctrl u_rwc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rd), .ack_o(ack), .op_valid_i(opv), .op_code_i(opc),
      .done_o(done), .add_en_o(adden), .src_win_o(src), .dst_win_o(dst),
      .trap_o(trap), .trap_type_o(ttype), .trap_other_o(toth),
      .irq_o(irq));

   rwc_pipe_model u_rwc_pipe_model (.clk_i(clk_i), .rst_i(rst_i),
      .req_i(req), .req_code_i(code), .op_valid_o(opv), .op_code_o(opc),
      .done_i(done), .trap_i(trap), .trap_type_i(ttype),
      .flush_ok_o(fok), .spills_o(spills));

   // ==========================================================
   // Shared tasks
   task close_out();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   function automatic logic [31:0] ws(input logic [2:0] p, s, r, c, o);
      ws = 32'h0;
      ws[POS_PTR +: 3] = p;
      ws[POS_SAVABLE +: 3] = s;
      ws[POS_RESTOR +: 3] = r;
      ws[POS_CLEAN +: 3] = c;
      ws[POS_OTHER +: 3] = o;
   endfunction

   // Called right after a rising edge; returns right after one
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         errors++;
         close_out();
      end
      rdat = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask

   task op(input logic [2:0] c, input rwc_trap_e et, input logic eo,
           input logic ed, input logic [31:0] ew);
      logic [2:0] p0;
      bus(1'b0, OFS_WSTATE, 32'h0);
      p0 = rdat[2:0];
      req <= 1'b1;
      code <= c;
      @(posedge clk_i);
      req <= 1'b0;
      @(posedge clk_i);
      @(posedge clk_i);
      chk("done", 32'(done), 32'(ed));
      chk("trap", 32'(trap), 32'(et != TR_NONE));
      chk("add", 32'(adden), 32'(ed && (c == OP_SAVE || c == OP_RESTORE)));
      if (et != TR_NONE)
      begin
         chk("type", 32'(ttype), 32'(et));
         chk("other", 32'(toth), 32'(eo));
      end
      if (ed && (c == OP_SAVE || c == OP_RESTORE))
      begin
         chk("src", 32'(src), 32'(p0));
         chk("dst", 32'(dst), 32'(ew[2:0]));
      end
      bus(1'b0, OFS_WSTATE, 32'h0);
      chk("wstate", rdat, ew);
   endtask

   // ==========================================================
   // Scenarios
   task t_reset();
      bus(1'b0, OFS_WSTATE, 32'h0);
      chk("rst", rdat, ws(3'h0, 3'h6, 3'h0, 3'h7, 3'h0));
      bus(1'b0, OFS_IMASK, 32'h0);
      chk("mask", rdat, 32'h0);
      bus(1'b1, 8'h0C, 32'hFFFFFFFF);
      bus(1'b0, 8'h0C, 32'h0);
      chk("unmapped", rdat, 32'h0);
   endtask

   task t_save_restore();
      for (int k = 0; k < 6; k++)
         op(OP_SAVE, TR_NONE, 0, 1, ws(k + 1, 5 - k, k + 1, 7, 0));
      op(OP_SAVE, TR_SPILL, 0, 0, ws(6, 0, 6, 7, 0));
      op(OP_RESTORE, TR_NONE, 0, 1, ws(5, 1, 5, 7, 0));
      bus(1'b1, OFS_WSTATE, ws(3, 0, 2, 7, 1));
      op(OP_SAVE, TR_SPILL, 1, 0, ws(3, 0, 2, 7, 1));
      bus(1'b1, OFS_WSTATE, ws(0, 1, 0, 7, 2));
      op(OP_RESTORE, TR_FILL, 1, 0, ws(0, 1, 0, 7, 2));
      bus(1'b1, OFS_WSTATE, ws(7, 2, 1, 7, 0));
      op(OP_SAVE, TR_NONE, 0, 1, ws(0, 1, 2, 7, 0));
      op(OP_RESTORE, TR_NONE, 0, 1, ws(7, 2, 1, 7, 0));
      bus(1'b1, OFS_WSTATE, ws(5, 2, 3, 3, 0));
      op(OP_SAVE, TR_CLEAN, 0, 0, ws(5, 2, 3, 3, 0));
   endtask

   task t_handler_ops();
      bus(1'b1, OFS_WSTATE, ws(2, 1, 3, 4, 2));
      op(OP_SAVED, TR_NONE, 0, 1, ws(2, 2, 3, 4, 1));
      bus(1'b1, OFS_WSTATE, ws(2, 1, 3, 4, 0));
      op(OP_SAVED, TR_NONE, 0, 1, ws(2, 2, 2, 4, 0));
      bus(1'b1, OFS_WSTATE, ws(2, 3, 1, 4, 1));
      op(OP_RESTORED, TR_NONE, 0, 1, ws(2, 3, 2, 5, 0));
      bus(1'b1, OFS_WSTATE, ws(2, 3, 1, 7, 0));
      op(OP_RESTORED, TR_NONE, 0, 1, ws(2, 2, 2, 7, 0));
      op(3'h4, TR_NONE, 0, 0, ws(2, 2, 2, 7, 0));
      op(3'h5, TR_NONE, 0, 0, ws(2, 2, 2, 7, 0));
   endtask

   task t_flush_irq();
      int n;
      bus(1'b1, OFS_WSTATE, ws(4, 6, 0, 7, 0));
      bus(1'b0, OFS_ISTAT, 32'h0);
      op(OP_FLUSH, TR_NONE, 0, 1, ws(4, 6, 0, 7, 0));
      bus(1'b1, OFS_WSTATE, ws(4, 3, 3, 7, 0));
      req <= 1'b1;
      code <= OP_FLUSH;
      @(posedge clk_i);
      req <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (fok !== 1'b1 && n < 60);
      chk("flushed", 32'(fok), 32'h1);
      chk("spills", 32'(spills), 32'h3);
      bus(1'b0, OFS_WSTATE, 32'h0);
      chk("wstate", rdat, ws(4, 6, 0, 7, 0));
      chk("irq", 32'(irq), 32'h1);
      bus(1'b1, OFS_IMASK, 32'h1);
      @(posedge clk_i);
      chk("irq", 32'(irq), 32'h0);
      bus(1'b0, OFS_IMASK, 32'h0);
      chk("mask", rdat, 32'h1);
      bus(1'b1, OFS_IMASK, 32'h0);
      @(posedge clk_i);
      chk("irq", 32'(irq), 32'h1);
      bus(1'b0, OFS_ISTAT, 32'h0);
      chk("stat", rdat, 32'h1);
      @(posedge clk_i);
      chk("irq", 32'(irq), 32'h0);
      bus(1'b0, OFS_ISTAT, 32'h0);
      chk("stat", rdat, 32'h0);
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      t_reset();
      t_save_restore();
      t_handler_ops();
      t_flush_irq();
      close_out();
   end
endmodule
